// >>> hdl/acv_top.sv
// converter pin-level control and parallel output, with an AXI4-Lite
// register file and one level interrupt
// assumes core_clk at 100 MHz; the converter pins are asynchronous to it, the AXI4-Lite bus is not
//
// Notes on behaviour
// - The four-level strap picks differential or single-ended clock and two's complement or offset binary output.
// - The power strap at full supply means power-down, at half supply sleep, at ground normal conversion.
// - In power-down only the reference stays alive and conversion stops.
// - Waking from sleep takes less time than waking from power-down.
// - A sample is taken at each falling edge of the conversion clock, in either clock style.
// - Each result is an 11-bit parallel word, bit 0 the least and bit 10 the most significant.
// - The over-range flag is high when the input lies outside codes 0 to 2047.
// - The data-ready strobe runs at the sampling rate with exactly one word per period.
// - The spare low-order output positions are held at ground.
`timescale 1ns/10ps
`include "acv_regs.svh"
module acv_top
#(
	parameter int AMP_W = 13,
	parameter int WORD_W = 11,
	parameter int SPARE_W = 3,
	parameter int ADDR_W = 8,
	parameter int SLP_WAKE_NS = `ACV_SLP_WAKE_NS,
	parameter int PD_WAKE_NS = `ACV_PD_WAKE_NS
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic conv_clk_p,
	input wire logic conv_clk_n,
	input wire logic [1:0] clock_style_format_strap,
	input wire logic [1:0] power_state_strap,
	input wire logic signed [AMP_W-1:0] analog_amplitude,
	output logic [WORD_W-1:0] sample_word_bits,
	output logic over_range_flag,
	output logic word_valid_strobe,
	output logic [SPARE_W-1:0] spare_output_ground,
	output logic ref_active,
	output logic conv_active,
	output acv_pkg::acv_pwr_t power_mode,
	output logic irq,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import acv_pkg::*;

	localparam int SLP_WAKE_CYC =
		(SLP_WAKE_NS + `ACV_CORE_CLK_NS - 1) / `ACV_CORE_CLK_NS;
	localparam int PD_WAKE_CYC =
		(PD_WAKE_NS + `ACV_CORE_CLK_NS - 1) / `ACV_CORE_CLK_NS;
	localparam int SYNC_W = 6 + AMP_W;
	localparam logic signed [AMP_W-1:0] CODE_MAX_S = AMP_W'(`ACV_CODE_MAX);
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	acv_cfg_if cfg_if();

	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic clk_p_s;
	logic clk_n_s;
	logic [1:0] csf_s;
	logic [1:0] pwr_s;
	logic signed [AMP_W-1:0] amp_s;
	logic clk_lvl;
	logic clk_prev_q;
	logic conv_fall;
	logic conv_rise;
	logic take;
	logic [WORD_W-1:0] fmt_code;
	logic fmt_over;
	acv_run_t st_q;
	acv_run_t st_d;
	logic [11:0] wake_cnt_q;
	logic ctrl_en_q;
	logic run;
	logic [WORD_W-1:0] word_q;
	logic over_q;
	logic strobe_q;
	logic [31:0] sample_cnt_q;
	acv_pwr_t pwr_prev_q;
	logic [`ACV_IRQ_W-1:0] irq_ev;
	logic [`ACV_IRQ_W-1:0] irq_clr;
	logic [`ACV_IRQ_W-1:0] irq_stat_q;
	logic [`ACV_IRQ_W-1:0] irq_mask_q;
	logic aw_hold_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic w_hold_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go;
	logic wr_hit;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] rd_word;
	logic rd_hit;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and strap decode

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {conv_clk_p, conv_clk_n, clock_style_format_strap,
				power_state_strap, analog_amplitude};
			sync2_q <= sync1_q;
		end
	end

	assign {clk_p_s, clk_n_s, csf_s, pwr_s, amp_s} = sync2_q;

	acv_strap_dec u_strap_dec
	(
		.core_clk(core_clk),
		.resetn(resetn),
		.csf_level(csf_s),
		.pwr_level(pwr_s),
		.cfg(cfg_if.dec)
	);

	////////////////////////////////////////////////////////////////////////
	// conversion clock edges

	// single-ended style listens to the positive input only
	assign clk_lvl = (cfg_if.clk_style == acv_clk_single) ? clk_p_s :
		(clk_p_s & ~clk_n_s);

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			clk_prev_q <= 1'b0;
		else
			clk_prev_q <= clk_lvl;
	end

	assign conv_fall = clk_prev_q & ~clk_lvl;
	assign conv_rise = ~clk_prev_q & clk_lvl;

	////////////////////////////////////////////////////////////////////////
	// power state machine

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
		acv_st_down:
			if (cfg_if.pwr == acv_pwr_normal)
				st_d = acv_st_wake;
			else if (cfg_if.pwr == acv_pwr_sleep)
				st_d = acv_st_sleep;
		acv_st_sleep:
			if (cfg_if.pwr == acv_pwr_normal)
				st_d = acv_st_wake;
			else if (cfg_if.pwr == acv_pwr_down)
				st_d = acv_st_down;
		acv_st_wake:
			if (cfg_if.pwr == acv_pwr_down)
				st_d = acv_st_down;
			else if (cfg_if.pwr == acv_pwr_sleep)
				st_d = acv_st_sleep;
			else if (wake_cnt_q == 12'h000)
				st_d = acv_st_run;
		acv_st_run:
			if (cfg_if.pwr == acv_pwr_down)
				st_d = acv_st_down;
			else if (cfg_if.pwr == acv_pwr_sleep)
				st_d = acv_st_sleep;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			st_q <= acv_st_down;
		else
			st_q <= st_d;
	end

	// recovery from sleep is the shorter count
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			wake_cnt_q <= 12'h000;
		else if (st_q != acv_st_wake && st_d == acv_st_wake)
			wake_cnt_q <= (st_q == acv_st_sleep) ? 12'(SLP_WAKE_CYC - 1) :
				12'(PD_WAKE_CYC - 1);
		else if (st_q == acv_st_wake && wake_cnt_q != 12'h000)
			wake_cnt_q <= wake_cnt_q - 12'h001;
	end

	assign run = (st_q == acv_st_run) && ctrl_en_q;
	assign take = conv_fall && run;
	assign ref_active = 1'b1;
	assign conv_active = run;
	assign power_mode = cfg_if.pwr;

	////////////////////////////////////////////////////////////////////////
	// output word, flag and strobe

	acv_out_fmt #(.AMP_W(AMP_W), .WORD_W(WORD_W)) u_out_fmt
	(
		.amplitude(amp_s),
		.cfg(cfg_if.sink),
		.code(fmt_code),
		.over(fmt_over)
	);

	// word and flag move only while the strobe is low
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			word_q <= '0;
			over_q <= 1'b0;
		end
		else if (take)
		begin
			word_q <= fmt_code;
			over_q <= fmt_over;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			strobe_q <= 1'b0;
		else if (!run || conv_fall)
			strobe_q <= 1'b0;
		else if (conv_rise)
			strobe_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			sample_cnt_q <= 32'h0000_0000;
		else if (take)
			sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
	end

	assign sample_word_bits = word_q;
	assign over_range_flag = over_q;
	assign word_valid_strobe = strobe_q;
	assign spare_output_ground = '0;

	////////////////////////////////////////////////////////////////////////
	// interrupt status and mask

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			pwr_prev_q <= acv_pwr_down;
		else
			pwr_prev_q <= cfg_if.pwr;
	end

	always_comb
	begin
		irq_ev = '0;
		irq_ev[`ACV_IRQ_OVR_BIT] = take && fmt_over;
		irq_ev[`ACV_IRQ_PWR_BIT] = pwr_prev_q != cfg_if.pwr;
		irq_ev[`ACV_IRQ_WAKE_BIT] = (st_q == acv_st_wake) &&
			(st_d == acv_st_run);
	end

	assign irq_clr = (wr_go && aw_addr_q == `ACV_IRQ_STAT_OFS &&
		w_strb_q[0]) ? w_data_q[`ACV_IRQ_W-1:0] : '0;

	// a new event beats a clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel

	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign wr_go = aw_hold_q && w_hold_q;
	assign wr_hit = aw_addr_q == `ACV_CTRL_OFS ||
		aw_addr_q == `ACV_STATUS_OFS || aw_addr_q == `ACV_IRQ_STAT_OFS ||
		aw_addr_q == `ACV_IRQ_MASK_OFS || aw_addr_q == `ACV_LAST_WORD_OFS ||
		aw_addr_q == `ACV_SAMPLE_CNT_OFS;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			aw_hold_q <= 1'b0;
			aw_addr_q <= '0;
		end
		else if (wr_go)
			aw_hold_q <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			w_hold_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else if (wr_go)
			w_hold_q <= 1'b0;
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			ctrl_en_q <= `ACV_CTRL_RST;
			irq_mask_q <= `ACV_IRQ_MASK_RST;
		end
		else if (wr_go && w_strb_q[0])
		begin
			if (aw_addr_q == `ACV_CTRL_OFS)
				ctrl_en_q <= w_data_q[`ACV_CTRL_EN_BIT];
			if (aw_addr_q == `ACV_IRQ_MASK_OFS)
				irq_mask_q <= w_data_q[`ACV_IRQ_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
		`ACV_CTRL_OFS:
			rd_word[`ACV_CTRL_EN_BIT] = ctrl_en_q;
		`ACV_STATUS_OFS:
			rd_word = {25'h000_0000, ref_active, st_q, cfg_if.pwr,
				cfg_if.fmt, cfg_if.clk_style};
		`ACV_IRQ_STAT_OFS:
			rd_word[`ACV_IRQ_W-1:0] = irq_stat_q;
		`ACV_IRQ_MASK_OFS:
			rd_word[`ACV_IRQ_W-1:0] = irq_mask_q;
		`ACV_LAST_WORD_OFS:
			rd_word = {15'h0000, over_q, 5'h00, word_q};
		`ACV_SAMPLE_CNT_OFS:
			rd_word = sample_cnt_q;
		default:
			rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_take;
		conv_fall && run;
	endsequence

	sequence s_rise;
		conv_rise && run;
	endsequence

	// three cycles: the state lags the decoded strap by one, the strobe by two
	pd_halt_a: assert property (
		(cfg_if.pwr == acv_pwr_down) [*3] |->
		!conv_active && $stable(word_q) && !word_valid_strobe)
		else $error("conversion active in power-down");
	sleep_wake_a: assert property (st_q == acv_st_sleep &&
		cfg_if.pwr == acv_pwr_normal |=> st_q == acv_st_wake &&
		wake_cnt_q == 12'(SLP_WAKE_CYC - 1) && SLP_WAKE_CYC < PD_WAKE_CYC)
		else $error("sleep recovery not shorter");
	fall_only_a: assert property ($changed(word_q) |-> $past(take))
		else $error("word changed without a falling edge");
	ob_code_a: assert property (s_take ##0
		(cfg_if.fmt == acv_fmt_offset && amp_s >= 0 &&
		amp_s <= CODE_MAX_S) |=>
		sample_word_bits == $past(amp_s[WORD_W-1:0]))
		else $error("offset binary word wrong");
	ovr_range_a: assert property (s_take |=>
		over_range_flag ==
		($past(amp_s) > CODE_MAX_S || $past(amp_s) < 0))
		else $error("over-range flag wrong");
	twos_msb_a: assert property (s_take ##0
		(cfg_if.fmt == acv_fmt_twos && amp_s >= 0 &&
		amp_s <= CODE_MAX_S) |=>
		sample_word_bits == {~$past(amp_s[WORD_W-1]),
		$past(amp_s[WORD_W-2:0])})
		else $error("two's complement msb not inverted");
	strobe_low_a: assert property (s_take |=> !word_valid_strobe)
		else $error("strobe not low after falling edge");
	strobe_high_a: assert property (s_rise |=> word_valid_strobe)
		else $error("strobe not high after rising edge");
	pair_stable_a: assert property (word_valid_strobe &&
		$past(word_valid_strobe) |-> $stable(word_q) && $stable(over_q))
		else $error("word or flag moved while strobe high");
	spare_gnd_a: assert property (take |=>
		spare_output_ground == '0)
		else $error("spare outputs not grounded");

endmodule // acv_top

// >>> hdl/acv_regs.svh
// register map, field positions, reset values and timing figures of the
// converter output block; assumes byte addressing on a 32-bit register bus
`ifndef ACV_REGS_SVH
`define ACV_REGS_SVH

`define ACV_CTRL_OFS 8'h00
`define ACV_STATUS_OFS 8'h04
`define ACV_IRQ_STAT_OFS 8'h08
`define ACV_IRQ_MASK_OFS 8'h0C
`define ACV_LAST_WORD_OFS 8'h10
`define ACV_SAMPLE_CNT_OFS 8'h14

`define ACV_CTRL_EN_BIT 0
`define ACV_CTRL_RST 1'h1
`define ACV_IRQ_W 3
`define ACV_IRQ_OVR_BIT 0
`define ACV_IRQ_PWR_BIT 1
`define ACV_IRQ_WAKE_BIT 2
`define ACV_IRQ_MASK_RST 3'h0

// strap level codes from the pin comparators
`define ACV_CSF_VA 2'h3
`define ACV_CSF_TWO_THIRDS 2'h2
`define ACV_CSF_ONE_THIRD 2'h1
`define ACV_CSF_GND 2'h0
`define ACV_PWR_LVL_VA 2'h2
`define ACV_PWR_LVL_HALF 2'h1
`define ACV_PWR_LVL_GND 2'h0

`define ACV_CODE_MAX 11'h7FF

`define ACV_CORE_CLK_NS 10
`define ACV_SLP_WAKE_NS 500
`define ACV_PD_WAKE_NS 3000

`endif

// >>> hdl/acv_pkg.sv
// types shared by the converter output block
// assumes nothing of its surroundings
package acv_pkg;

	typedef enum logic {acv_clk_diff, acv_clk_single} acv_clk_style_t;
	typedef enum logic {acv_fmt_offset, acv_fmt_twos} acv_fmt_t;
	typedef enum logic [1:0] {acv_pwr_normal, acv_pwr_sleep,
		acv_pwr_down} acv_pwr_t;
	typedef enum logic [1:0] {acv_st_down, acv_st_sleep, acv_st_wake,
		acv_st_run} acv_run_t;

endpackage // acv_pkg

// >>> hdl/acv_cfg_if.sv
// decoded strap settings passed from the decoder to their users
// assumes one driver, the strap decoder
`timescale 1ns/10ps
interface acv_cfg_if;
	import acv_pkg::*;
	acv_clk_style_t clk_style;
	acv_fmt_t fmt;
	acv_pwr_t pwr;
	modport dec (output clk_style, output fmt, output pwr);
	modport sink (input clk_style, input fmt, input pwr);
endinterface // acv_cfg_if

// >>> hdl/acv_strap_dec.sv
// decoder of the clock/format strap and the power strap
// assumes strap levels already synchronised to core_clk
`timescale 1ns/10ps
`include "acv_regs.svh"
module acv_strap_dec
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [1:0] csf_level,
	input wire logic [1:0] pwr_level,
	acv_cfg_if.dec cfg
);
	import acv_pkg::*;

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			cfg.clk_style <= acv_clk_diff;
			cfg.fmt <= acv_fmt_offset;
		end
		else
		begin
			unique case (csf_level)
			`ACV_CSF_VA:
			begin
				cfg.clk_style <= acv_clk_diff;
				cfg.fmt <= acv_fmt_twos;
			end
			`ACV_CSF_TWO_THIRDS:
			begin
				cfg.clk_style <= acv_clk_diff;
				cfg.fmt <= acv_fmt_offset;
			end
			`ACV_CSF_ONE_THIRD:
			begin
				cfg.clk_style <= acv_clk_single;
				cfg.fmt <= acv_fmt_twos;
			end
			`ACV_CSF_GND:
			begin
				cfg.clk_style <= acv_clk_single;
				cfg.fmt <= acv_fmt_offset;
			end
			endcase
		end
	end

	// an undefined power level is taken as power-down, the safe side
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			cfg.pwr <= acv_pwr_down;
		else if (pwr_level == `ACV_PWR_LVL_GND)
			cfg.pwr <= acv_pwr_normal;
		else if (pwr_level == `ACV_PWR_LVL_HALF)
			cfg.pwr <= acv_pwr_sleep;
		else
			cfg.pwr <= acv_pwr_down;
	end

	csf_single_a: assert property (@(posedge core_clk)
		disable iff (!resetn) csf_level == `ACV_CSF_ONE_THIRD |=>
		cfg.clk_style == acv_clk_single && cfg.fmt == acv_fmt_twos)
		else $error("strap 1/3 misdecoded");
	pwr_sleep_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		pwr_level == `ACV_PWR_LVL_HALF |=> cfg.pwr == acv_pwr_sleep)
		else $error("half-supply power strap not sleep");

endmodule // acv_strap_dec

// >>> hdl/acv_out_fmt.sv
// clamps an input amplitude to the output code span and applies the format
// assumes the amplitude is a signed count of code steps
`timescale 1ns/10ps
`include "acv_regs.svh"
module acv_out_fmt
#(
	parameter int AMP_W = 13,
	parameter int WORD_W = 11
)
(
	input wire logic signed [AMP_W-1:0] amplitude,
	acv_cfg_if.sink cfg,
	output logic [WORD_W-1:0] code,
	output logic over
);
	import acv_pkg::*;

	localparam logic signed [AMP_W-1:0] CODE_MAX = AMP_W'(`ACV_CODE_MAX);

	logic [WORD_W-1:0] ob_code;

	always_comb
	begin
		over = (amplitude < 0) || (amplitude > CODE_MAX);
		if (amplitude < 0)
			ob_code = '0;
		else if (amplitude > CODE_MAX)
			ob_code = '1;
		else
			ob_code = amplitude[WORD_W-1:0];
		code = ob_code;
		if (cfg.fmt == acv_fmt_twos)
			code[WORD_W-1] = ~ob_code[WORD_W-1];
	end

endmodule // acv_out_fmt

// >>> test/acv_capture_model.sv
// capture logic beside the converter output: latches word and flag
// assumes strobe, word and flag come straight from the converter pins
`timescale 1ns/10ps
module acv_capture_model
(
	input wire logic word_valid_strobe,
	input wire logic [10:0] sample_word_bits,
	input wire logic over_range_flag,
	output logic [10:0] cap_word,
	output logic cap_over,
	output int cap_count
);
	initial
	begin
		cap_word = 11'h000;
		cap_over = 1'b0;
		cap_count = 0;
		forever
		begin
			@(posedge word_valid_strobe);
			cap_word <= sample_word_bits;
			cap_over <= over_range_flag;
			cap_count <= cap_count + 1;
		end
	end
endmodule // acv_capture_model

// >>> test/test_adc_output_and_mode_pins.sv
// self-checking bench for the converter output block
// assumes the design sources and the capture model are compiled first
`timescale 1ns/10ps
`include "acv_regs.svh"
module test_adc_output_and_mode_pins;
	import acv_pkg::*;
	localparam int LIMIT = 20000;
	logic core_clk, resetn, clk_p, clk_n, diff_mode;
	logic [1:0] csf, pwr, bresp, rresp;
	logic signed [12:0] amp;
	logic [10:0] word, cap_word;
	logic over, strobe, ref_act, conv_act, irq, cap_over;
	logic [2:0] spare;
	acv_pwr_t pmode;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	int cap_count, err_count, checks;
	int cyc = 0;

	acv_top #(.SLP_WAKE_NS(30), .PD_WAKE_NS(60)) u_dut
	(
		.core_clk(core_clk), .resetn(resetn),
		.conv_clk_p(clk_p), .conv_clk_n(clk_n),
		.clock_style_format_strap(csf), .power_state_strap(pwr),
		.analog_amplitude(amp), .sample_word_bits(word),
		.over_range_flag(over), .word_valid_strobe(strobe),
		.spare_output_ground(spare), .ref_active(ref_act),
		.conv_active(conv_act), .power_mode(pmode), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready)
	);

	acv_capture_model u_cap
	(
		.word_valid_strobe(strobe), .sample_word_bits(word),
		.over_range_flag(over), .cap_word(cap_word),
		.cap_over(cap_over), .cap_count(cap_count)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// conversion clock runs free, phase unrelated to core_clk
	initial
	begin
		clk_p = 1'b0;
		clk_n = 1'b0;
		#3.3;
		forever
		begin
			#62.5 clk_p = ~clk_p;
			clk_n = diff_mode ? ~clk_p : 1'b0;
		end
	end

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			err_count++;
			wrap_up;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task wrap_up;
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] exp_resp);
		bit aw_done = 0;
		bit w_done = 0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge core_clk);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", exp_resp, bresp);
	endtask

	task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] exp_resp);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", exp_resp, rresp);
		chk("rdata", exp, rdata);
	endtask

	function automatic logic [10:0] exp_word(input int a, input logic twos);
		logic [10:0] w;
		w = (a < 0) ? 11'h000 : (a > 2047) ? 11'h7ff : a[10:0];
		return {w[10] ^ twos, w[9:0]};
	endfunction

	task automatic set_amp(input int v);
		@(posedge clk_p);
		@(posedge core_clk);
		amp <= v[12:0];
		repeat (3) @(posedge clk_p);
		@(posedge core_clk);
	endtask

	task automatic wake_time(input logic [1:0] from, output int n);
		@(posedge core_clk);
		pwr <= from;
		repeat (40) @(posedge core_clk);
		chk("conv_active", 0, conv_act);
		pwr <= 2'h0;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (conv_act !== 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		chk("spare", 0, spare);
		chk("ref_active", 1, ref_act);
		reg_chk(`ACV_CTRL_OFS, 32'h0000_0001, 2'h0);
		reg_chk(`ACV_IRQ_MASK_OFS, 32'h0000_0000, 2'h0);
		reg_chk(8'h40, 32'h0000_0000, 2'h2);
		axi_write(8'h40, 32'h0000_0001, 2'h2);
	endtask

	task t_formats;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge core_clk);
			csf <= k[1:0];
			diff_mode = (k >= 2);
			set_amp(1234);
			set_amp(5 + k);
			chk("word", exp_word(5 + k, k[0]), cap_word);
			reg_chk(`ACV_STATUS_OFS, {25'h000_0000, 5'h1c, k[0], ~k[1]},
				2'h0);
		end
	endtask

	task t_over;
		int amps [4] = '{-5, 3000, 2047, 0};
		axi_write(`ACV_IRQ_MASK_OFS, 32'h0000_0001, 2'h0);
		for (int i = 0; i < 4; i++)
		begin
			set_amp(amps[i]);
			chk("word", exp_word(amps[i], 1'b1), cap_word);
			chk("over", amps[i] < 0 || amps[i] > 2047, cap_over);
			if (i == 1)
				reg_chk(`ACV_LAST_WORD_OFS, 32'h0001_03ff, 2'h0);
		end
		chk("irq", 1, irq);
		axi_write(`ACV_IRQ_STAT_OFS, 32'h0000_0007, 2'h0);
		chk("irq", 0, irq);
		axi_write(`ACV_IRQ_MASK_OFS, 32'h0000_0000, 2'h0);
		set_amp(-1);
		chk("irq", 0, irq);
		set_amp(100);
	endtask

	task t_rate;
		int n0;
		axi_write(`ACV_CTRL_OFS, 32'h0000_0000, 2'h0);
		n0 = cap_count;
		repeat (4) @(posedge clk_p);
		@(posedge core_clk);
		chk("conv_active", 0, conv_act);
		chk("strobes", 0, cap_count - n0);
		axi_write(`ACV_CTRL_OFS, 32'h0000_0001, 2'h0);
		@(posedge clk_p);
		n0 = cap_count;
		repeat (16) @(posedge clk_p);
		chk("strobes", 16, cap_count - n0);
	endtask

	task t_power;
		int n0, down_cyc, sleep_cyc;
		@(posedge core_clk);
		pwr <= 2'h2;
		repeat (20) @(posedge core_clk);
		chk("power_mode", acv_pwr_down, pmode);
		chk("ref_active", 1, ref_act);
		n0 = cap_count;
		repeat (4) @(posedge clk_p);
		chk("strobes", 0, cap_count - n0);
		@(posedge core_clk);
		pwr <= 2'h1;
		repeat (20) @(posedge core_clk);
		chk("power_mode", acv_pwr_sleep, pmode);
		wake_time(2'h2, down_cyc);
		chk("power_mode", acv_pwr_normal, pmode);
		wake_time(2'h1, sleep_cyc);
		chk("sleep_faster", 1, sleep_cyc < down_cyc);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		resetn = 1'b0;
		diff_mode = 1'b1;
		csf = 2'h3;
		pwr = 2'h0;
		amp = 13'h0000;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{err_count, checks} = '0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_reset();
		while (conv_act !== 1'b1)
			@(posedge core_clk);
		t_formats();
		t_over();
		t_rate();
		t_power();
		wrap_up;
	end
endmodule // test_adc_output_and_mode_pins
